// ### hdl/rdo_pkg.sv
// Holds the constants and types that the rail disable override block uses.
// Assumes nothing of its surroundings; it is imported by every design file except rdo_sync.
package rdo_pkg;

   localparam int DATA_W = 8;
   localparam int RAIL_CNT = 5;

   // Rail indices on the rail vectors.
   localparam int RAIL_TERM = 0;
   localparam int RAIL_AGRP = 1;
   localparam int RAIL_BSW1 = 2;
   localparam int RAIL_BSW2 = 3;
   localparam int RAIL_LIN1 = 4;

   // Field positions of the override register.
   localparam int BIT_SEL_RAIL = 7;
   localparam int BIT_BSW1 = 6;
   localparam int BIT_AGRP = 5;
   localparam int BIT_TERM = 4;
   localparam int RSVD_HI = 3;
   localparam int RSVD_LO = 0;

   // Register pointer, reset value and serial target address.
   localparam logic [7:0] OVR_REG_PTR = 8'h9F;
   localparam logic [7:0] OVR_RESET = 8'hF0;
   // Arbitrary target address.
   localparam logic [6:0] TARGET_ADDR = 7'h5A;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_ADDR      = 4'h1,
      ST_ADDR_ACK  = 4'h2,
      ST_PTR       = 4'h3,
      ST_PTR_ACK   = 4'h4,
      ST_WDATA     = 4'h5,
      ST_WDATA_ACK = 4'h6,
      ST_RDATA     = 4'h7,
      ST_RDATA_ACK = 4'h8
   } rdo_state_type;

endpackage

// ### hdl/rdo_sync.sv
// Holds a two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to CLK; only the second stage is read.
`timescale 1ns/1ps
module rdo_sync #(
   parameter int WIDTH = 2
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   // Levels.
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sync_out
);

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               meta_q <= 1'b1;
               sync_q <= 1'b1;
            end else if (ce) begin
               meta_q <= pin_in[gi];
               sync_q <= meta_q;
            end
         end
         assign sync_out[gi] = sync_q;
      end
   endgenerate

endmodule // rdo_sync

// ### hdl/rdo_top.sv
// Holds the rail disable override register, its two-wire serial target and rail gating.
// Assumes rail requests and force-on bits come from logic on CLK; pins are asynchronous.
//
// How it works
// - Bit 7 at zero turns the factory-selected rail off, ignoring control pins.
// - A factory strap picks whether bit 7 governs switch two or linear regulator.
// - Bit 6 at zero forces B-group switch one off; one restores normal control.
// - Bit 5 at zero forces the A-group switch off; one restores normal control.
// - Bit 4 at zero forces the termination regulator off; one restores control.
// - A force-on request only acts while the matching disable bit is one.
`timescale 1ns/1ps
module rdo_top (
   // Clock, reset and enable.
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic CE,
   // Two-wire serial port.
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // Factory configuration.
   input wire logic SEL_IS_LINEAR_REG,
   // Rail requests.
   input wire logic [rdo_pkg::RAIL_CNT-1:0] RAIL_PIN_REQ,
   input wire logic [rdo_pkg::RAIL_CNT-1:0] RAIL_FORCE_ON,
   // Rail enables and register view.
   output logic [rdo_pkg::RAIL_CNT-1:0] RAIL_ENABLE,
   output logic [rdo_pkg::DATA_W-1:0] OVERRIDE_VALUE
);
   import rdo_pkg::*;

   logic [1:0] pins_sync;
   logic scl_s;
   logic sda_s;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   rdo_state_type state_q;
   logic [7:0] shift_q;
   logic [3:0] cnt_q;
   logic rnw_q;
   logic [7:0] ptr_q;
   logic sda_oe_q;
   logic sda_out_q;
   logic [7:0] ovr_q;
   logic [7:0] read_val;
   logic wr_strobe;
   logic sel_lin_q;
   logic strap_done_q;
   logic [RAIL_CNT-1:0] off_n;
   logic [RAIL_CNT-1:0] rail_en_q;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and bus events.

   rdo_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(CLK),
      .arst_n(ARST_N),
      .ce(CE),
      .pin_in({SCL_IN, SDA_IN}),
      .sync_out(pins_sync)
   );

   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else if (CE) begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   assign read_val = (ptr_q == OVR_REG_PTR) ? ovr_q : UNMAPPED_READ;
   assign wr_strobe = CE && scl_fall && (state_q == ST_WDATA) && (cnt_q == BITS_PER_BYTE);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Serial target state machine.

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_q <= ST_IDLE;
         shift_q <= 8'h00;
         cnt_q <= 4'h0;
         rnw_q <= 1'b0;
         ptr_q <= 8'h00;
         sda_oe_q <= 1'b0;
      end else if (CE) begin
         if (start_det) begin
            state_q <= ST_ADDR;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
         end else if (stop_det) begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
         end else if (scl_rise) begin
            unique case (state_q)
               ST_ADDR, ST_PTR, ST_WDATA: begin
                  shift_q <= {shift_q[6:0], sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end
               ST_RDATA_ACK: begin
                  rnw_q <= ~sda_s;
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            unique case (state_q)
               ST_ADDR: begin
                  if (cnt_q == BITS_PER_BYTE) begin
                     if (shift_q[7:1] == TARGET_ADDR) begin
                        rnw_q <= shift_q[0];
                        state_q <= ST_ADDR_ACK;
                        sda_oe_q <= 1'b1;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  cnt_q <= 4'h0;
                  if (rnw_q) begin
                     state_q <= ST_RDATA;
                     shift_q <= {read_val[6:0], 1'b0};
                     cnt_q <= 4'h1;
                     sda_oe_q <= ~read_val[7];
                  end else begin
                     state_q <= ST_PTR;
                     sda_oe_q <= 1'b0;
                  end
               end
               ST_PTR: begin
                  if (cnt_q == BITS_PER_BYTE) begin
                     ptr_q <= shift_q;
                     state_q <= ST_PTR_ACK;
                     sda_oe_q <= 1'b1;
                  end
               end
               ST_WDATA: begin
                  if (cnt_q == BITS_PER_BYTE) begin
                     state_q <= ST_WDATA_ACK;
                     sda_oe_q <= 1'b1;
                  end
               end
               ST_PTR_ACK, ST_WDATA_ACK: begin
                  state_q <= ST_WDATA;
                  cnt_q <= 4'h0;
                  sda_oe_q <= 1'b0;
               end
               ST_RDATA: begin
                  if (cnt_q == BITS_PER_BYTE) begin
                     state_q <= ST_RDATA_ACK;
                     sda_oe_q <= 1'b0;
                  end else begin
                     sda_oe_q <= ~shift_q[7];
                     shift_q <= {shift_q[6:0], 1'b0};
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
               ST_RDATA_ACK: begin
                  if (rnw_q) begin
                     state_q <= ST_RDATA;
                     shift_q <= {read_val[6:0], 1'b0};
                     cnt_q <= 4'h1;
                     sda_oe_q <= ~read_val[7];
                  end else begin
                     state_q <= ST_IDLE;
                     sda_oe_q <= 1'b0;
                  end
               end
               ST_IDLE: begin
                  sda_oe_q <= 1'b0;
               end
               default: begin
                  state_q <= ST_IDLE;
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sda_out_q <= 1'b0;
      end else if (CE) begin
         sda_out_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Override register; reserved bits are stored as written and the host keeps them zero.

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ovr_q <= OVR_RESET;
      end else if (wr_strobe && (ptr_q == OVR_REG_PTR)) begin
         ovr_q <= shift_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Factory strap capture after reset release.

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sel_lin_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (CE && !strap_done_q) begin
         sel_lin_q <= SEL_IS_LINEAR_REG;
         strap_done_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Rail gating.

   always_comb begin
      off_n = '1;
      off_n[RAIL_TERM] = ovr_q[BIT_TERM];
      off_n[RAIL_AGRP] = ovr_q[BIT_AGRP];
      off_n[RAIL_BSW1] = ovr_q[BIT_BSW1];
      off_n[RAIL_BSW2] = sel_lin_q | ovr_q[BIT_SEL_RAIL];
      off_n[RAIL_LIN1] = ~sel_lin_q | ovr_q[BIT_SEL_RAIL];
   end

   genvar gr;
   generate
      for (gr = 0; gr < RAIL_CNT; gr++) begin : g_rail
         always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               rail_en_q[gr] <= 1'b0;
            end else if (CE) begin
               rail_en_q[gr] <= strap_done_q & off_n[gr] & (RAIL_PIN_REQ[gr] | RAIL_FORCE_ON[gr]);
            end
         end
      end
   endgenerate

   assign RAIL_ENABLE = rail_en_q;
   assign OVERRIDE_VALUE = ovr_q;
   assign SDA_OE = sda_oe_q;
   assign SDA_OUT = sda_out_q;

endmodule // rdo_top

// ### sim/rdo_monitor.sv
// Concurrent checks on the rail gating of the override block.
// Assumes it is bound to rdo_top and that the strap is held steady.
`timescale 1ns/1ps
module rdo_monitor (
   // Clock, reset and enable.
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic CE,
   // Rail side.
   input wire logic SEL_IS_LINEAR_REG,
   input wire logic [rdo_pkg::RAIL_CNT-1:0] RAIL_PIN_REQ,
   input wire logic [rdo_pkg::RAIL_CNT-1:0] RAIL_FORCE_ON,
   input wire logic [rdo_pkg::RAIL_CNT-1:0] RAIL_ENABLE,
   input wire logic [rdo_pkg::DATA_W-1:0] OVERRIDE_VALUE
);
   import rdo_pkg::*;
   logic [RAIL_CNT-1:0] want;
   logic free_req, free_en;
   assign want = RAIL_PIN_REQ | RAIL_FORCE_ON;
   assign free_req = SEL_IS_LINEAR_REG ? want[RAIL_BSW2] : want[RAIL_LIN1];
   assign free_en = SEL_IS_LINEAR_REG ? RAIL_ENABLE[RAIL_BSW2] : RAIL_ENABLE[RAIL_LIN1];
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   ////////////////////////////////////////////////////////////////////////////////
   a_sel_rail_off: assert property (
      !$past(OVERRIDE_VALUE[BIT_SEL_RAIL])
      |-> !RAIL_ENABLE[SEL_IS_LINEAR_REG ? RAIL_LIN1 : RAIL_BSW2])
      else $error("Selected rail on while disabled.");
   a_free_rail_follows: assert property (
      $past(ARST_N) && $past(ARST_N, 2) && $past(CE) && $past(free_req) |-> free_en)
      else $error("Unselected rail ignores its request.");
   a_bsw1_off: assert property (
      !$past(OVERRIDE_VALUE[BIT_BSW1]) |-> !RAIL_ENABLE[RAIL_BSW1])
      else $error("B-group switch one on while disabled.");
   a_agrp_off: assert property (
      !$past(OVERRIDE_VALUE[BIT_AGRP]) |-> !RAIL_ENABLE[RAIL_AGRP])
      else $error("A-group switch on while disabled.");
   a_term_off: assert property (
      !$past(OVERRIDE_VALUE[BIT_TERM]) |-> !RAIL_ENABLE[RAIL_TERM])
      else $error("Termination regulator on while disabled.");
   a_force_on_term: assert property (
      $past(ARST_N) && $past(ARST_N, 2) && $past(CE)
      && $past(OVERRIDE_VALUE[BIT_TERM]) && $past(RAIL_FORCE_ON[RAIL_TERM])
      |-> RAIL_ENABLE[RAIL_TERM])
      else $error("Force-on ignored while enabled.");
endmodule // rdo_monitor
////////////////////////////////////////////////////////////////////////////////
bind rdo_top rdo_monitor u_mon (
   .CLK(CLK),
   .ARST_N(ARST_N),
   .CE(CE),
   .SEL_IS_LINEAR_REG(SEL_IS_LINEAR_REG),
   .RAIL_PIN_REQ(RAIL_PIN_REQ),
   .RAIL_FORCE_ON(RAIL_FORCE_ON),
   .RAIL_ENABLE(RAIL_ENABLE),
   .OVERRIDE_VALUE(OVERRIDE_VALUE)
);

// ### sim/test_rail_disable_override_reg.sv
// Self-checking bench for the rail disable override block.
// Assumes rdo_pkg and rdo_top are compiled first; the monitor is bound.
`timescale 1ns/1ps
module test_rail_disable_override_reg;
   import rdo_pkg::*;
   logic clk = 0, arst_n = 0, ce = 1, scl = 1, sda_m = 1, strap = 0, sda_oe, sda_o;
   logic [4:0] req = 0, frc = 0, rail;
   logic [7:0] ovr, ov;
   logic [15:0] exp_q[$];
   int err_count = 0, cmp_count = 0;
   event pr;
   wire sda = sda_m & ~sda_oe;
   rdo_top DUT (
      .CLK(clk), .ARST_N(arst_n), .CE(ce), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(sda_o), .SDA_OE(sda_oe), .SEL_IS_LINEAR_REG(strap),
      .RAIL_PIN_REQ(req), .RAIL_FORCE_ON(frc), .RAIL_ENABLE(rail),
      .OVERRIDE_VALUE(ovr)
   );
   initial begin
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (err_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic half();
      repeat (6) @(negedge clk);
   endtask
   task automatic probe(input logic oe);
      logic [4:0] on;
      on = {ov[7] | ~strap, ov[7] | strap, ov[6], ov[5], ov[4]};
      exp_q.push_back({oe, 2'b00, on & (req | frc), ov});
      -> pr;
   endtask
   task automatic put(input logic [7:0] b, input logic oe, input logic [7:0] nv);
      for (int i = 7; i >= 0; i--) begin
         sda_m = b[i];
         half();
         scl = 1;
         half();
         scl = 0;
      end
      sda_m = 1;
      ov = nv;
      half();
      scl = 1;
      probe(oe);
      half();
      scl = 0;
   endtask
   task automatic frame(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
      logic m;
      m = (a === TARGET_ADDR);
      sda_m = 0;
      half();
      scl = 0;
      put({a, 1'b0}, m, ov);
      put(p, m, ov);
      put(d, m, (m && p === OVR_REG_PTR) ? d : ov);
      sda_m = 0;
      half();
      scl = 1;
      half();
      sda_m = 1;
      half();
   endtask
   task automatic fetch(input logic [7:0] p);
      logic [7:0] v;
      v = (p === OVR_REG_PTR) ? ov : UNMAPPED_READ;
      sda_m = 0;
      half();
      scl = 0;
      put({TARGET_ADDR, 1'b0}, 1'b1, ov);
      put(p, 1'b1, ov);
      sda_m = 1;
      half();
      scl = 1;
      half();
      sda_m = 0;
      half();
      scl = 0;
      put({TARGET_ADDR, 1'b1}, 1'b1, ov);
      for (int i = 7; i >= 0; i--) begin
         half();
         scl = 1;
         probe(~v[i]);
         half();
         scl = 0;
      end
      half();
      scl = 1;
      probe(1'b0);
      half();
      scl = 0;
      sda_m = 0;
      half();
      scl = 1;
      half();
      sda_m = 1;
      half();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin : watch
      logic [15:0] e;
      forever begin
         @(pr);
         e = exp_q.pop_front();
         cmp_count++;
         if ({sda_oe, sda_o, 1'b0, rail, ovr} !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time,
               {sda_oe, sda_o, 1'b0, rail, ovr}, e);
         end
      end
   end
   initial begin
      #2_000_000;
      err_count++;
      end_of_test();
   end
   initial begin
      ov = OVR_RESET;
      void'($urandom(32'h17000379));
      for (int s = 0; s < 2; s++) begin
         @(negedge clk);
         arst_n = 0;
         strap = s[0];
         ov = OVR_RESET;
         repeat (16) @(negedge clk);
         arst_n = 1;
         repeat (4) @(negedge clk);
         probe(0);
         for (int k = 0; k < 6; k++) begin
            frame(TARGET_ADDR, OVR_REG_PTR,
               k == 0 ? 8'h00 : k == 1 ? 8'hF0 : {4'($urandom), 4'h0});
            req = 5'($urandom);
            frc = k == 0 ? 5'h1F : 5'($urandom);
            repeat (2) @(negedge clk);
            probe(0);
         end
         frame(TARGET_ADDR + 7'h01, OVR_REG_PTR, 8'h00);
         frame(TARGET_ADDR, OVR_REG_PTR - 8'h01, 8'h00);
         ce = 0;
         req = ~req;
         repeat (2) @(negedge clk);
         req = ~req;
         probe(0);
         ce = 1;
         fetch(OVR_REG_PTR);
         fetch(OVR_REG_PTR - 8'h01);
         probe(0);
      end
      end_of_test();
   end
endmodule // test_rail_disable_override_reg
